//--- dv/fwc_ctrl_props.sv
`timescale 1ns/1ps
module fwc_ctrl_props
    import fwc_pkg::*;
#(
    parameter int ERASE_REP = 2
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_we,
    input wire logic cpu_flash_acc,
    input wire logic cpu_from_ram,
    input wire logic cpu_slow_clk,
    input wire logic cpu_fetch_stall,
    input wire logic access_violation,
    input wire logic dma_trigger,
    input wire logic flash_prog_en,
    input wire logic flash_erase_en,
    input wire logic [fwc_pkg::WORD_ADDR_W-1:0] flash_word_addr,
    input wire logic [31:0] flash_prog_data,
    input wire logic flash_power_down
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // stall is combinational, so it must follow its causes in the same cycle
    property p_stall; cpu_fetch_stall == (cpu_flash_acc && !cpu_from_ram && flash_prog_en); endproperty
    a_stall: assert property (p_stall) else $error("fetch stall wrong");
    property p_viol; access_violation == $past(cpu_flash_acc && cpu_from_ram && flash_prog_en); endproperty
    a_viol: assert property (p_viol) else $error("violation pulse wrong");
    property p_pd; flash_power_down |-> cpu_slow_clk && !cpu_flash_acc && !flash_prog_en; endproperty
    a_pd: assert property (p_pd) else $error("power down at wrong time");
    property p_cause; $rose(flash_prog_en) |-> $past(reg_we && reg_addr == ADDR_WRITE_DATA); endproperty
    a_cause: assert property (p_cause) else $error("program without data byte");
    property p_inc; $fell(flash_prog_en) |-> flash_word_addr == WORD_ADDR_W'($past(flash_word_addr) + 1); endproperty
    a_inc: assert property (p_inc) else $error("address not advanced");
    property p_hold; flash_prog_en && $past(flash_prog_en) |-> $stable(flash_prog_data) && $stable(flash_word_addr); endproperty
    a_hold: assert property (p_hold) else $error("word moved while programming");
    property p_excl; !(flash_prog_en && flash_erase_en); endproperty
    a_excl: assert property (p_excl) else $error("erase and program overlap");
    property p_notrig; flash_prog_en || flash_erase_en |-> !dma_trigger; endproperty
    a_notrig: assert property (p_notrig) else $error("trigger while flash busy");
    property p_donetrig; $fell(flash_prog_en) |-> dma_trigger; endproperty
    a_donetrig: assert property (p_donetrig) else $error("no trigger after word");
    c_word: cover property ($fell(flash_prog_en));
    c_erase: cover property ($fell(flash_erase_en));
    c_viol: cover property (access_violation);
endmodule : fwc_ctrl_props

bind fwc_ctrl fwc_ctrl_props #(.ERASE_REP(ERASE_REP)) u_props (.clk(clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_we(reg_we), .cpu_flash_acc(cpu_flash_acc),
    .cpu_from_ram(cpu_from_ram), .cpu_slow_clk(cpu_slow_clk),
    .cpu_fetch_stall(cpu_fetch_stall), .access_violation(access_violation),
    .dma_trigger(dma_trigger), .flash_prog_en(flash_prog_en), .flash_erase_en(flash_erase_en),
    .flash_word_addr(flash_word_addr), .flash_prog_data(flash_prog_data),
    .flash_power_down(flash_power_down));

//--- dv/fwc_flash_model.sv
`timescale 1ns/1ps
module fwc_flash_model
    import fwc_pkg::*;
(
    input wire logic clk,
    input wire logic prog_en,
    input wire logic erase_en,
    input wire logic [fwc_pkg::WORD_ADDR_W-1:0] word_addr,
    input wire logic [fwc_pkg::PAGE_W-1:0] erase_page,
    input wire logic [31:0] prog_data,
    output logic word_stb,
    output logic [fwc_pkg::WORD_ADDR_W-1:0] word_addr_q,
    output logic [31:0] word_q
);
    logic [31:0] mem [int];
    logic prog_d = 1'b0;
    logic erase_d = 1'b0;
    initial word_stb = 1'b0;
    // cells only clear bits: an unerased word reads back as zero, so skipped erases show
    always @(posedge clk) begin
        word_stb <= 1'b0;
        prog_d <= prog_en;
        erase_d <= erase_en;
        if (erase_en && !erase_d) begin
            for (int i = 0; i < PAGE_BYTES / WORD_BYTES; i++) begin
                mem[{erase_page, i[8:0]}] = '1;
            end
        end
        if (prog_en && !prog_d) begin
            mem[word_addr] = mem.exists(word_addr) ? mem[word_addr] & prog_data : 32'h0;
            word_q <= mem[word_addr];
            word_addr_q <= word_addr;
            word_stb <= 1'b1;
        end
    end
endmodule : fwc_flash_model

//--- dv/tb_flash_word_write_controller.sv
`timescale 1ns/1ps
module tb_flash_word_write_controller;
    import fwc_pkg::*;
    localparam int EREP = 2;
    localparam int TIM = 1;
    logic clk, nrst, reg_we, reg_re, cpu_flash_acc, cpu_from_ram, cpu_slow_clk, re_d;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic cpu_fetch_stall, access_violation, dma_trigger, flash_prog_en, flash_erase_en;
    logic flash_power_down, word_stb;
    logic viol_exp = 1'b0;
    logic [WORD_ADDR_W-1:0] flash_word_addr, word_addr_q;
    logic [PAGE_W-1:0] flash_erase_page;
    logic [31:0] flash_prog_data, word_q, w;
    logic [46:0] q_word[$];
    logic [7:0] q_rd[$];
    int n_mismatch = 0;
    int compares = 0;
    int seed = 32'hea98;
    int prog_len = 0;
    int erase_len = 0;
    int i;

    fwc_ctrl #(.ERASE_REP(EREP)) u_dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
        .cpu_flash_acc(cpu_flash_acc), .cpu_from_ram(cpu_from_ram),
        .cpu_slow_clk(cpu_slow_clk), .cpu_fetch_stall(cpu_fetch_stall),
        .access_violation(access_violation), .dma_trigger(dma_trigger),
        .flash_prog_en(flash_prog_en), .flash_erase_en(flash_erase_en),
        .flash_word_addr(flash_word_addr), .flash_erase_page(flash_erase_page),
        .flash_prog_data(flash_prog_data), .flash_power_down(flash_power_down));
    fwc_flash_model u_flash (.clk(clk), .prog_en(flash_prog_en), .erase_en(flash_erase_en),
        .word_addr(flash_word_addr), .erase_page(flash_erase_page),
        .prog_data(flash_prog_data), .word_stb(word_stb), .word_addr_q(word_addr_q),
        .word_q(word_q));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic check(input string what, input logic [46:0] seen, input logic [46:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic conclude;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : conclude

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        @(posedge clk);
        reg_we <= 1'b0;
    endtask : wr

    // the expected read value is noted now and compared when the data stands
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_re <= 1'b1;
        q_rd.push_back(exp);
        @(posedge clk);
        reg_re <= 1'b0;
    endtask : rd

    // dma style feed: one byte per trigger, bounded wait
    task automatic feed(input logic [7:0] d);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (!dma_trigger && n < 300);
        if (!dma_trigger) begin
            check("dma_trigger", 0, 1);
            conclude();
        end
        wr(ADDR_WRITE_DATA, d);
    endtask : feed

    // first look a half cycle on, so a word launched at this edge is seen
    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while ((flash_prog_en || flash_erase_en) && n < 300);
        if (n >= 300) begin
            check("idle_wait", 0, 1);
            conclude();
        end
    endtask : wait_idle

    // random cpu activity keeps stall, violation and power down logic busy
    always @(posedge clk) begin
        cpu_flash_acc <= 1'($random(seed));
        cpu_from_ram <= 1'($random(seed));
        cpu_slow_clk <= 1'($random(seed));
        re_d <= reg_re;
        viol_exp <= cpu_flash_acc && cpu_from_ram && flash_prog_en;
    end

    // watcher: compared mid-cycle so the edge updates have landed
    always @(negedge clk) begin
        if (re_d) begin
            if (q_rd.size() == 0) check("read_note", 1, 0);
            else check("reg_rdata", reg_rdata, q_rd.pop_front());
        end
        if (word_stb) begin
            if (q_word.size() == 0) check("word_note", 1, 0);
            else check("word", {word_addr_q, word_q}, q_word.pop_front());
        end
        check("fetch_stall", 47'(cpu_fetch_stall), 47'(cpu_flash_acc && !cpu_from_ram && flash_prog_en));
        check("access_violation", 47'(access_violation), 47'(viol_exp));
        if (flash_prog_en) prog_len++;
        else if (prog_len != 0) begin
            check("prog_len", 47'(prog_len), 47'(16 * TIM + 1));
            prog_len = 0;
        end
        if (flash_erase_en) erase_len++;
        else if (erase_len != 0) begin
            check("erase_len", 47'(erase_len), 47'(16 * TIM * EREP + 1));
            erase_len = 0;
        end
    end

    initial begin
        nrst = 1'b0;
        reg_we = 1'b0;
        reg_re = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        cpu_flash_acc = 1'b0;
        cpu_from_ram = 1'b0;
        cpu_slow_clk = 1'b0;
        re_d = 1'b0;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        rd(ADDR_TIMING, 8'h2a);
        rd(ADDR_ADDR_HIGH, 8'h00);
        rd(ADDR_CONTROL, 8'h00);
        rd(8'ha0, 8'h00);
        wr(ADDR_TIMING, 8'(TIM));
        wr(ADDR_ADDR_HIGH, 8'h02);
        wr(ADDR_ADDR_LOW, 8'hfd);
        wr(ADDR_CONTROL, 8'h01);
        rd(ADDR_CONTROL, 8'h81);
        check("erase_page", 47'(flash_erase_page), 47'(1));
        wr(ADDR_TIMING, 8'h05); // refused while busy, word length proves it
        wait_idle();
        wr(ADDR_CONTROL, 8'h02);
        @(negedge clk);
        check("start_trig", 47'(dma_trigger), 47'(1));
        for (int k = 0; k < 3; k++) begin
            w = $random(seed);
            q_word.push_back({WORD_ADDR_W'(15'h2fd + k), w});
            for (int b = 0; b < 4; b++) begin
                if (k == 0 && b == 0) wr(ADDR_WRITE_DATA, w[7:0]);
                else feed(w[8*b +: 8]);
            end
            if (k == 0) rd(ADDR_CONTROL, 8'hc2);
            if (k == 1) wr(ADDR_WRITE_DATA, 8'h5a); // dropped during programming
        end
        wait_idle();
        wr(ADDR_CONTROL, 8'h00);
        rd(ADDR_CONTROL, 8'h00);
        rd(ADDR_ADDR_HIGH, 8'h03);
        rd(ADDR_ADDR_LOW, 8'h00);
        repeat (4) @(posedge clk);
        conclude();
    end
endmodule : tb_flash_word_write_controller

//--- hdl/fwc_ctrl.sv
// Behaviour
// - flash is 64 pages of 2048 bytes; erasure works on whole pages
// - bytes are readable singly; programming happens only as whole 32-bit words
// - timing generator makes a page erase last about 20 ms; at the 4 ns clock an erase takes 2.7 ms at reset timing, 4 ms at most
// - timing generator makes one word program last about 20 us; at the 4 ns clock a word takes 2.7 us at reset timing, 4 us at most
// - flash powered down between reads while cpu runs on slow clock
// - writing one to the write-start bit begins a write sequence
// - programming starts at the word address high:low
// - word busy flag is high exactly while one word is programmed
// - in a sequence, every fourth data byte programs one word
// - one sequence programs any number of consecutive words
// - dma trigger pulses whenever the data register can take a byte
// - starting a write issues the first dma trigger at once
// - cpu fetches from flash stall during word programming
// - flash access from ram code while word busy flags a violation
// - timing field resets to 0x2a and is software writable
// - erase bit erases page high[6:1]; erase completes before write
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/1ps
module fwc_ctrl #(
    parameter int ERASE_REP = fwc_pkg::ERASE_PER_PROG
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [7:0] reg_rdata,
    input wire logic cpu_flash_acc,
    input wire logic cpu_from_ram,
    input wire logic cpu_slow_clk,
    output logic cpu_fetch_stall,
    output logic access_violation,
    output logic dma_trigger,
    output logic flash_prog_en,
    output logic flash_erase_en,
    output logic [fwc_pkg::WORD_ADDR_W-1:0] flash_word_addr,
    output logic [fwc_pkg::PAGE_W-1:0] flash_erase_page,
    output logic [31:0] flash_prog_data,
    output logic flash_power_down
);
    import fwc_pkg::*;

    fwc_tmr_if tmr ();

    fwc_timer #(
        .ERASE_REP(ERASE_REP)
    ) u_timer (
        .clk(clk),
        .nrst(nrst),
        .tmr(tmr)
    );

    fwc_state_t state, next_state;
    logic [TIMING_W-1:0] flash_write_timing, next_flash_write_timing;
    logic [7:0] flash_addr_low, next_flash_addr_low;
    logic [7:0] flash_addr_high, next_flash_addr_high;
    logic [7:0] pack [3];
    logic [7:0] next_pack [3];
    logic [1:0] byte_cnt, next_byte_cnt;
    logic write_pend, next_write_pend;
    logic stop_pend, next_stop_pend;
    logic [31:0] prog_data, next_prog_data;
    logic trig, next_trig;
    logic viol, next_viol;
    logic [7:0] rdata, next_rdata;
    logic start, erase_sel;
    logic ctl_wr, data_wr;
    logic word_write_busy;
    logic busy;
    logic [15:0] word_addr_cat;
    logic [15:0] word_addr_inc;
    logic [7:0] flash_control_reg;

    assign ctl_wr = reg_we && (reg_addr == ADDR_CONTROL);
    assign data_wr = reg_we && (reg_addr == ADDR_WRITE_DATA);
    assign word_write_busy = (state == FWC_PROG);
    assign busy = (state != FWC_IDLE);
    // the address registers hold a word address; upper bit of high is unused
    assign word_addr_cat = {flash_addr_high, flash_addr_low};
    assign word_addr_inc = word_addr_cat + 16'h0001;

    // control register view: status bits come from the sequencer itself
    always_comb begin
        flash_control_reg = 8'h00;
        flash_control_reg[CTL_BUSY_BIT] = busy;
        flash_control_reg[CTL_WORD_BUSY_BIT] = word_write_busy;
        flash_control_reg[CTL_ERASE_BIT] = (state == FWC_ERASE);
        flash_control_reg[CTL_WRITE_BIT] = (state == FWC_COLLECT) || (state == FWC_PROG);
    end

    // sequencer: erase first, then collect bytes and program words
    always_comb begin
        next_state = state;
        next_flash_addr_low = flash_addr_low;
        next_flash_addr_high = flash_addr_high;
        next_flash_write_timing = flash_write_timing;
        for (int i = 0; i < 3; i++) begin
            next_pack[i] = pack[i];
        end
        next_byte_cnt = byte_cnt;
        next_write_pend = write_pend;
        next_stop_pend = stop_pend;
        next_prog_data = prog_data;
        next_trig = 1'b0;
        start = 1'b0;
        erase_sel = 1'b0;
        // address and timing are only taken while idle, so a sequence
        // cannot be retargeted halfway through a word
        if (reg_we && (state == FWC_IDLE)) begin
            if (reg_addr == ADDR_TIMING) begin
                next_flash_write_timing = reg_wdata[TIMING_W-1:0];
            end
            if (reg_addr == ADDR_ADDR_LOW) begin
                next_flash_addr_low = reg_wdata;
            end
            if (reg_addr == ADDR_ADDR_HIGH) begin
                next_flash_addr_high = reg_wdata;
            end
        end
        unique case (state)
            FWC_IDLE: begin
                next_byte_cnt = 2'd0;
                next_stop_pend = 1'b0;
                if (ctl_wr && reg_wdata[CTL_ERASE_BIT]) begin
                    start = 1'b1;
                    erase_sel = 1'b1;
                    next_write_pend = reg_wdata[CTL_WRITE_BIT];
                    next_state = FWC_ERASE;
                end else if (ctl_wr && reg_wdata[CTL_WRITE_BIT]) begin
                    next_trig = 1'b1;
                    next_state = FWC_COLLECT;
                end
            end
            FWC_ERASE: begin
                if (tmr.done) begin
                    next_write_pend = 1'b0;
                    if (write_pend) begin
                        next_trig = 1'b1;
                        next_state = FWC_COLLECT;
                    end else begin
                        next_state = FWC_IDLE;
                    end
                end
            end
            FWC_COLLECT: begin
                if (ctl_wr && !reg_wdata[CTL_WRITE_BIT]) begin
                    // clearing the write bit ends the sequence; a partial word
                    // is dropped because flash only takes whole words
                    next_state = FWC_IDLE;
                end else if (data_wr) begin
                    if (byte_cnt == 2'd3) begin
                        // first byte lands in the low lane of the word
                        next_prog_data = {reg_wdata, pack[2], pack[1], pack[0]};
                        next_byte_cnt = 2'd0;
                        start = 1'b1;
                        next_state = FWC_PROG;
                    end else begin
                        next_pack[byte_cnt] = reg_wdata;
                        next_byte_cnt = byte_cnt + 2'd1;
                        next_trig = 1'b1;
                    end
                end
            end
            FWC_PROG: begin
                // bytes written while a word is in flight are ignored
                if (ctl_wr && !reg_wdata[CTL_WRITE_BIT]) begin
                    next_stop_pend = 1'b1;
                end
                if (tmr.done) begin
                    next_flash_addr_high = word_addr_inc[15:8];
                    next_flash_addr_low = word_addr_inc[7:0];
                    if (stop_pend || (ctl_wr && !reg_wdata[CTL_WRITE_BIT])) begin
                        next_state = FWC_IDLE;
                    end else begin
                        next_trig = 1'b1;
                        next_state = FWC_COLLECT;
                    end
                end
            end
        endcase
    end

    assign tmr.start = start;
    assign tmr.erase = erase_sel;
    assign tmr.timing = flash_write_timing;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= FWC_IDLE;
            flash_write_timing <= TIMING_RESET;
            flash_addr_low <= ADDR_LOW_RESET;
            flash_addr_high <= ADDR_HIGH_RESET;
            for (int i = 0; i < 3; i++) begin
                pack[i] <= 8'h00;
            end
            byte_cnt <= 2'd0;
            write_pend <= 1'b0;
            stop_pend <= 1'b0;
            prog_data <= 32'h0000_0000;
            trig <= 1'b0;
        end else begin
            state <= next_state;
            flash_write_timing <= next_flash_write_timing;
            flash_addr_low <= next_flash_addr_low;
            flash_addr_high <= next_flash_addr_high;
            for (int i = 0; i < 3; i++) begin
                pack[i] <= next_pack[i];
            end
            byte_cnt <= next_byte_cnt;
            write_pend <= next_write_pend;
            stop_pend <= next_stop_pend;
            prog_data <= next_prog_data;
            trig <= next_trig;
        end
    end

    // register read port: data in the cycle after the strobe, zero elsewhere
    always_comb begin
        next_rdata = 8'h00;
        if (reg_re) begin
            unique case (reg_addr)
                ADDR_TIMING: next_rdata = {2'b00, flash_write_timing};
                ADDR_ADDR_LOW: next_rdata = flash_addr_low;
                ADDR_ADDR_HIGH: next_rdata = flash_addr_high;
                ADDR_CONTROL: next_rdata = flash_control_reg;
                default: next_rdata = 8'h00; // write data reads as zero
            endcase
        end
    end

    // ram code touching flash mid-word is a fault, flash code just waits
    always_comb begin
        next_viol = cpu_flash_acc && cpu_from_ram && word_write_busy;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata <= 8'h00;
            viol <= 1'b0;
        end else begin
            rdata <= next_rdata;
            viol <= next_viol;
        end
    end

    assign reg_rdata = rdata;
    assign access_violation = viol;
    assign dma_trigger = trig;
    // stall is combinational so the fetch never sees a half-written word
    assign cpu_fetch_stall = cpu_flash_acc && !cpu_from_ram && word_write_busy;
    // power down only while nothing reads and no operation is running
    assign flash_power_down = cpu_slow_clk && !cpu_flash_acc && !busy;
    assign flash_prog_en = word_write_busy;
    assign flash_erase_en = (state == FWC_ERASE);
    assign flash_word_addr = word_addr_cat[WORD_ADDR_W-1:0];
    assign flash_erase_page = flash_addr_high[PAGE_LSB +: PAGE_W];
    assign flash_prog_data = prog_data;
endmodule : fwc_ctrl

//--- hdl/fwc_pkg.sv
package fwc_pkg;
    // register offsets on the plain register port
    localparam logic [7:0] ADDR_TIMING = 8'ha8;
    localparam logic [7:0] ADDR_ADDR_LOW = 8'ha9;
    localparam logic [7:0] ADDR_ADDR_HIGH = 8'haa;
    localparam logic [7:0] ADDR_CONTROL = 8'hae;
    localparam logic [7:0] ADDR_WRITE_DATA = 8'haf;

    // control register fields
    localparam int CTL_ERASE_BIT = 0;
    localparam int CTL_WRITE_BIT = 1;
    localparam int CTL_WORD_BUSY_BIT = 6;
    localparam int CTL_BUSY_BIT = 7;

    // flash geometry
    localparam int PAGE_COUNT = 64;
    localparam int PAGE_BYTES = 2048;
    localparam int WORD_BYTES = 4;
    localparam int WORD_ADDR_W = $clog2(PAGE_COUNT * PAGE_BYTES / WORD_BYTES);
    localparam int PAGE_W = $clog2(PAGE_COUNT);
    localparam int PAGE_LSB = 1;
    localparam int TIMING_W = 6;

    // reset values
    localparam logic [TIMING_W-1:0] TIMING_RESET = 6'h2a;
    localparam logic [7:0] ADDR_LOW_RESET = 8'h00;
    localparam logic [7:0] ADDR_HIGH_RESET = 8'h00;

    // timing: one timing unit is sixteen clocks, a word takes timing units,
    // an erase takes as many word times as the ratio of the two durations
    localparam int CLK_PERIOD_NS = 4;
    localparam int PROG_TIME_NS = 20000;
    localparam int ERASE_TIME_NS = 20000000;
    localparam int UNIT_CYCLES = 16;
    localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ERASE_PER_PROG = ERASE_TIME_NS / PROG_TIME_NS;

    typedef enum logic [1:0] {
        FWC_IDLE = 2'b00,
        FWC_ERASE = 2'b01,
        FWC_COLLECT = 2'b11,
        FWC_PROG = 2'b10
    } fwc_state_t;
endpackage : fwc_pkg

//--- hdl/fwc_timer.sv
`timescale 1ns/1ps
module fwc_timer #(
    parameter int ERASE_REP = fwc_pkg::ERASE_PER_PROG
) (
    input wire logic clk,
    input wire logic nrst,
    fwc_tmr_if.timer tmr
);
    import fwc_pkg::*;
    localparam int REP_W = $clog2(ERASE_REP + 1);
    localparam logic [3:0] UNIT_LAST = 4'(UNIT_CYCLES - 1);
    localparam logic [REP_W-1:0] REP_LAST = REP_W'(ERASE_REP - 1);

    logic run, next_run;
    logic done, next_done;
    logic [3:0] unit, next_unit;
    logic [TIMING_W-1:0] tcnt, next_tcnt;
    logic [TIMING_W-1:0] tload, next_tload;
    logic [REP_W-1:0] rep, next_rep;

    // nested down counters: unit, then timing value, then erase repeats
    always_comb begin
        next_run = run;
        next_done = 1'b0;
        next_unit = unit;
        next_tcnt = tcnt;
        next_tload = tload;
        next_rep = rep;
        if (tmr.start) begin
            next_run = 1'b1;
            next_unit = UNIT_LAST;
            // a zero timing value would mean no delay; treat it as one unit
            next_tload = (tmr.timing == '0) ? '0 : tmr.timing - 6'h01;
            next_tcnt = next_tload;
            next_rep = tmr.erase ? REP_LAST : '0;
        end else if (run) begin
            if (unit != 4'h0) begin
                next_unit = unit - 4'h1;
            end else begin
                next_unit = UNIT_LAST;
                if (tcnt != '0) begin
                    next_tcnt = tcnt - 6'h01;
                end else begin
                    next_tcnt = tload;
                    if (rep != '0) begin
                        next_rep = rep - REP_W'(1);
                    end else begin
                        next_run = 1'b0;
                        next_done = 1'b1;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            run <= 1'b0;
            done <= 1'b0;
            unit <= '0;
            tcnt <= '0;
            tload <= '0;
            rep <= '0;
        end else begin
            run <= next_run;
            done <= next_done;
            unit <= next_unit;
            tcnt <= next_tcnt;
            tload <= next_tload;
            rep <= next_rep;
        end
    end

    assign tmr.done = done;
    assign tmr.running = run;
endmodule : fwc_timer

//--- hdl/fwc_tmr_if.sv
`timescale 1ns/1ps
interface fwc_tmr_if;
    import fwc_pkg::*;
    logic start;
    logic erase;
    logic [TIMING_W-1:0] timing;
    logic done;
    logic running;
    modport ctrl (output start, output erase, output timing, input done, input running);
    modport timer (input start, input erase, input timing, output done, output running);
endinterface : fwc_tmr_if
